// file: pkg/frl_map.svh
// Register offsets, field positions, limits and timing counts of the flow filter
`ifndef FRL_MAP_SVH
`define FRL_MAP_SVH
// ==============================================================
// Register byte offsets
`define FRL_A_RATE    6'h00
`define FRL_A_HOLD    6'h04
`define FRL_A_CUT     6'h08
`define FRL_A_DSEL    6'h0C
`define FRL_A_CMD     6'h10
`define FRL_A_STATUS  6'h14
`define FRL_A_CLEAR   6'h18
`define FRL_A_ENABLE  6'h1C
`define FRL_A_STATE   6'h20
// ==============================================================
// Field positions
`define FRL_CMD_OK     0
`define FRL_CMD_CANCEL 1
`define FRL_ST_ERR     0
`define FRL_ST_CUT     1
`define FRL_ST_REJ     2
`define FRL_ST_APPLY   3
// ==============================================================
// Limits in 0.1 % of span, seconds
`define FRL_RATE_MAX  9'h12C
`define FRL_CUT_MAX   7'h64
`define FRL_HOLD_MAX  5'h14
// ==============================================================
// Timing: one sample per interval, samples per second derived
`define FRL_SAMPLE_MS 50
`define FRL_SPS       9'((1000 / `FRL_SAMPLE_MS))
// Bus answers
`define FRL_OKAY      2'h0
`define FRL_SLVERR    2'h2
`endif

// file: pkg/frl_pkg.sv
// Types shared by the flow filter modules
`default_nettype none
package frl_pkg;
  // Bus channel states, one-hot
  typedef enum logic [1:0] {FRL_IDLE = 2'h1, FRL_RESP = 2'h2} frl_bus_t;
  // One full filter configuration
  typedef struct packed {
    logic [8:0] rate;
    logic [4:0] hold;
    logic [6:0] cut;
    logic       dsel;
  } frl_cfg_t;
endpackage
`default_nettype wire

// file: rtl/frl_limiter.sv
// Rate-of-change limiter with persistence hold
`timescale 1ns/1ps
`default_nettype none
`include "frl_map.svh"
module frl_limiter (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        in_valid,
  input  wire logic [15:0] in_value,
  input  wire logic [8:0]  rate_change_threshold,
  input  wire logic [4:0]  persist_hold_time,
  output logic             out_valid,
  output logic [15:0]      out_value,
  output logic             rejected
);
  typedef struct packed {
    logic        vld;
    logic [15:0] avg;
    logic        rej;
    logic        dir;
    logic [8:0]  cnt;
  } frl_lim_st_t;
  frl_lim_st_t st;
  frl_lim_st_t next_st;
  logic [16:0] diff;
  logic [16:0] mag;
  logic        off;
  logic        over;
  logic        up;
  logic [8:0]  run;
  logic [8:0]  holds;
  logic [15:0] step_up;
  logic [15:0] step_dn;

  // ==============================================================
  // Next average per sample
  always_comb
  begin
    next_st = st;
    next_st.vld = in_valid;
    next_st.rej = 1'b0;
    diff = {in_value[15], in_value} - {st.avg[15], st.avg};
    mag = diff[16] ? 17'(-diff) : diff;
    up = !diff[16];
    off = (rate_change_threshold == 9'h000) || (persist_hold_time == 5'h00);
    over = mag > {8'h00, rate_change_threshold};
    holds = {4'h0, persist_hold_time} * `FRL_SPS;
    run = (st.cnt != 9'h000 && st.dir == up) ? st.cnt + 9'h001 : 9'h001;
    step_up = st.avg + {7'h00, rate_change_threshold};
    step_dn = st.avg - {7'h00, rate_change_threshold};
    if (in_valid)
    begin
      if (off || !over || run > holds)
      begin
        next_st.avg = in_value;
        next_st.cnt = 9'h000;
      end
      else
      begin
        next_st.avg = up ? step_up : step_dn;
        next_st.cnt = run;
        next_st.dir = up;
        next_st.rej = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign out_valid = st.vld;
  assign out_value = st.avg;
  assign rejected  = st.rej;

  // ==============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_off_pass:
    assert property (in_valid && off |=> out_value == $past(in_value))
      else $error("limiter not bypassed when off");
  a_step_clamp:
    assert property (in_valid && !off && over && run <= holds
      |=> rejected && out_value == ($past(up) ? $past(step_up) : $past(step_dn)))
      else $error("rejected sample not clamped to limit");
  a_hold_accept:
    assert property (in_valid && !off && over && run > holds
      |=> !rejected && out_value == $past(in_value))
      else $error("persistent change not accepted");
endmodule
`default_nettype wire

// file: rtl/frl_cutoff.sv
// Low cutoff with release hysteresis, display selection and pulse gate
`timescale 1ns/1ps
`default_nettype none
`include "frl_map.svh"
module frl_cutoff (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        in_valid,
  input  wire logic [15:0] in_value,
  input  wire logic [6:0]  cutoff_threshold,
  input  wire logic        display_cutoff_select,
  input  wire logic        pulse_req,
  output logic             out_valid,
  output logic [15:0]      current_value,
  output logic [15:0]      display_value,
  output logic [15:0]      comm_value,
  output logic             cut_active,
  output logic             cut_enter,
  output logic             pulse_out
);
  typedef struct packed {
    logic        vld;
    logic        cut;
    logic        ent;
    logic        pls;
    logic [15:0] cur;
    logic [15:0] disp;
  } frl_cut_st_t;
  frl_cut_st_t st;
  frl_cut_st_t next_st;
  logic [15:0] mag;
  logic [8:0]  c5;
  logic        rel;
  logic        cut_nx;

  // ==============================================================
  // Cutoff decision and value forcing
  always_comb
  begin
    next_st = st;
    next_st.vld = in_valid;
    next_st.ent = 1'b0;
    mag = in_value[15] ? 16'(-in_value) : in_value;
    c5 = {cutoff_threshold, 2'h0} + {2'h0, cutoff_threshold};
    rel = {mag, 2'h0} > {9'h000, c5};
    cut_nx = st.cut ? !rel : (mag <= {9'h000, cutoff_threshold});
    next_st.pls = pulse_req && !st.cut;
    if (in_valid)
    begin
      next_st.cut = cut_nx;
      next_st.ent = cut_nx && !st.cut;
      next_st.cur = cut_nx ? 16'h0000 : in_value;
      next_st.disp = (display_cutoff_select && cut_nx) ? 16'h0000 : in_value;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign out_valid     = st.vld;
  assign current_value = st.cur;
  assign display_value = st.disp;
  assign comm_value    = st.disp;
  assign cut_active    = st.cut;
  assign cut_enter     = st.ent;
  assign pulse_out     = st.pls;

  // ==============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_cut_zero:
    assert property (out_valid && cut_active |-> current_value == 16'h0000)
      else $error("current output not zero under cutoff");
  a_pulse_stop:
    assert property (cut_active |=> !pulse_out)
      else $error("totalizer pulse during cutoff");
  a_disp_bypass:
    assert property (in_valid && !display_cutoff_select |=> display_value == $past(in_value))
      else $error("bypass display value altered");
  a_release_hyst:
    assert property (cut_active && in_valid && !rel |=> cut_active)
      else $error("cutoff left below hysteresis point");
  a_comm_same:
    assert property (in_valid |=> comm_value
      == (($past(display_cutoff_select) && cut_active) ? 16'h0000 : $past(in_value)))
      else $error("link value not display cutoff processed");
endmodule
`default_nettype wire

// file: rtl/frl_flow_limit.sv
// Flow filter top: register slave, parameter commit, limiter and cutoff
// ==============================================================
`timescale 1ns/1ps
`default_nettype none
`include "frl_map.svh"
module frl_flow_limit (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sample stream and totalizer
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_value,
  input  wire logic        pulse_req,
  output logic             out_valid,
  output logic [15:0]      current_value,
  output logic [15:0]      display_value,
  output logic [15:0]      comm_value,
  output logic             pulse_out,
  output logic             irq
);
  typedef struct packed {
    frl_pkg::frl_bus_t ws;
    frl_pkg::frl_bus_t rs;
    logic              aw_got;
    logic              w_got;
    logic [5:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    frl_pkg::frl_cfg_t edit;
    frl_pkg::frl_cfg_t stored;
    frl_pkg::frl_cfg_t active;
    logic              pend;
    logic [3:0]        status;
    logic [3:0]        enable;
    logic              irq;
  } frl_top_st_t;
  frl_top_st_t st;
  frl_top_st_t next_st;

  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        wr_go;
  logic [5:0]  waddr;
  logic [31:0] wdat;
  logic [3:0]  wstb;
  logic [31:0] cmdw;
  logic        cmd_ok;
  logic        cmd_cancel;
  logic [3:0]  clr;
  logic [3:0]  set;
  logic        err;
  logic        applied;
  logic        lim_valid;
  logic [15:0] lim_value;
  logic        lim_rej;
  logic        cut_active;
  logic        cut_enter;

  // ==============================================================
  // Byte-lane merge for a register write
  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0]  stb
  );
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (stb[i])
        m[8*i +: 8] = dat[8*i +: 8];
    end
    return m;
  endfunction

  // ==============================================================
  // Bus slave, commit logic, status and interrupt
  always_comb
  begin
    next_st = st;
    cmd_ok = 1'b0;
    cmd_cancel = 1'b0;
    clr = 4'h0;
    err = 1'b0;
    applied = 1'b0;
    cmdw = 32'h0000_0000;
    aw_hs = s_axi_awvalid && st.awready;
    w_hs = s_axi_wvalid && st.wready;
    ar_hs = s_axi_arvalid && st.arready;
    // Address and data are taken in either order
    if (aw_hs)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    waddr = next_st.awaddr;
    wdat = next_st.wdata;
    wstb = next_st.wstrb;
    wr_go = (st.ws == frl_pkg::FRL_IDLE) && next_st.aw_got && next_st.w_got;
    // Register write
    if (wr_go)
    begin
      next_st.ws = frl_pkg::FRL_RESP;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `FRL_OKAY;
      case (waddr)
        `FRL_A_RATE:
          next_st.edit.rate = 9'(wmerge({23'h00_0000, st.edit.rate}, wdat, wstb));
        `FRL_A_HOLD:
          next_st.edit.hold = 5'(wmerge({27'h000_0000, st.edit.hold}, wdat, wstb));
        `FRL_A_CUT:
          next_st.edit.cut = 7'(wmerge({25'h000_0000, st.edit.cut}, wdat, wstb));
        `FRL_A_DSEL:
          next_st.edit.dsel = 1'(wmerge({31'h0000_0000, st.edit.dsel}, wdat, wstb));
        `FRL_A_CMD:
        begin
          cmdw = wmerge(32'h0000_0000, wdat, wstb);
          cmd_ok = cmdw[`FRL_CMD_OK];
          cmd_cancel = cmdw[`FRL_CMD_CANCEL];
        end
        `FRL_A_CLEAR:
          clr = 4'(wmerge(32'h0000_0000, wdat, wstb));
        `FRL_A_ENABLE:
          next_st.enable = 4'(wmerge({28'h000_0000, st.enable}, wdat, wstb));
        `FRL_A_STATUS, `FRL_A_STATE:
          next_st.bresp = `FRL_OKAY;
        default:
          next_st.bresp = `FRL_SLVERR;
      endcase
    end
    if (st.ws == frl_pkg::FRL_RESP && s_axi_bready)
    begin
      next_st.ws = frl_pkg::FRL_IDLE;
      next_st.bvalid = 1'b0;
    end
    next_st.awready = (next_st.ws == frl_pkg::FRL_IDLE) && !next_st.aw_got;
    next_st.wready = (next_st.ws == frl_pkg::FRL_IDLE) && !next_st.w_got;
    // Register read
    if (ar_hs)
    begin
      next_st.rs = frl_pkg::FRL_RESP;
      next_st.rvalid = 1'b1;
      next_st.rresp = `FRL_OKAY;
      case (s_axi_araddr)
        `FRL_A_RATE:   next_st.rdata = {23'h00_0000, st.edit.rate};
        `FRL_A_HOLD:   next_st.rdata = {27'h000_0000, st.edit.hold};
        `FRL_A_CUT:    next_st.rdata = {25'h000_0000, st.edit.cut};
        `FRL_A_DSEL:   next_st.rdata = {31'h0000_0000, st.edit.dsel};
        `FRL_A_STATUS: next_st.rdata = {28'h000_0000, st.status};
        `FRL_A_ENABLE: next_st.rdata = {28'h000_0000, st.enable};
        `FRL_A_STATE:  next_st.rdata = {lim_value, 14'h0000, st.pend, cut_active};
        `FRL_A_CMD, `FRL_A_CLEAR:
          next_st.rdata = 32'h0000_0000;
        default:
        begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = `FRL_SLVERR;
        end
      endcase
    end
    if (st.rs == frl_pkg::FRL_RESP && s_axi_rready)
    begin
      next_st.rs = frl_pkg::FRL_IDLE;
      next_st.rvalid = 1'b0;
    end
    next_st.arready = (next_st.rs == frl_pkg::FRL_IDLE);
    // Load stored settings while no sample is in flight
    if (st.pend && !sample_valid && !lim_valid)
    begin
      next_st.active = st.stored;
      next_st.pend = 1'b0;
      applied = 1'b1;
    end
    // Cancel wins over confirm in the same write
    if (cmd_cancel)
      next_st.edit = st.stored;
    else if (cmd_ok)
    begin
      // Each out-of-range field is refused and its edit restored
      if (st.edit.rate > `FRL_RATE_MAX)
      begin
        err = 1'b1;
        next_st.edit.rate = st.stored.rate;
      end
      else
        next_st.stored.rate = st.edit.rate;
      if (st.edit.cut > `FRL_CUT_MAX)
      begin
        err = 1'b1;
        next_st.edit.cut = st.stored.cut;
      end
      else
        next_st.stored.cut = st.edit.cut;
      if (st.edit.hold > `FRL_HOLD_MAX)
      begin
        err = 1'b1;
        next_st.edit.hold = st.stored.hold;
      end
      else
        next_st.stored.hold = st.edit.hold;
      next_st.stored.dsel = st.edit.dsel;
      next_st.pend = 1'b1;
    end
    // Sticky status: a new event beats a clear in the same cycle
    set = 4'h0;
    set[`FRL_ST_ERR] = err;
    set[`FRL_ST_CUT] = cut_enter;
    set[`FRL_ST_REJ] = lim_rej;
    set[`FRL_ST_APPLY] = applied;
    next_st.status = (st.status & ~clr) | set;
    next_st.irq = |(next_st.status & next_st.enable);
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.ws <= frl_pkg::FRL_IDLE;
      st.rs <= frl_pkg::FRL_IDLE;
    end
    else
      st <= next_st;
  end

  // ==============================================================
  // Bus outputs straight from the state register
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign irq           = st.irq;

  // ==============================================================
  // Limiter stage
  frl_limiter u_lim (
    .clk_sys               (clk_sys),
    .rstn                  (rstn),
    .in_valid              (sample_valid),
    .in_value              (sample_value),
    .rate_change_threshold (st.active.rate),
    .persist_hold_time     (st.active.hold),
    .out_valid             (lim_valid),
    .out_value             (lim_value),
    .rejected              (lim_rej)
  );

  // Cutoff stage
  frl_cutoff u_cut (
    .clk_sys               (clk_sys),
    .rstn                  (rstn),
    .in_valid              (lim_valid),
    .in_value              (lim_value),
    .cutoff_threshold      (st.active.cut),
    .display_cutoff_select (st.active.dsel),
    .pulse_req             (pulse_req),
    .out_valid             (out_valid),
    .current_value         (current_value),
    .display_value         (display_value),
    .comm_value            (comm_value),
    .cut_active            (cut_active),
    .cut_enter             (cut_enter),
    .pulse_out             (pulse_out)
  );

  // ==============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_bad_rate;
    cmd_ok && !cmd_cancel && st.edit.rate > `FRL_RATE_MAX;
  endsequence
  sequence s_bad_cut;
    cmd_ok && !cmd_cancel && st.edit.cut > `FRL_CUT_MAX;
  endsequence
  a_rate_kept:
    assert property (s_bad_rate |=> st.stored.rate == $past(st.stored.rate)
      && st.status[`FRL_ST_ERR] && st.edit.rate == st.stored.rate)
      else $error("bad limit stored or not flagged");
  a_cut_kept:
    assert property (s_bad_cut |=> st.stored.cut == $past(st.stored.cut)
      && st.status[`FRL_ST_ERR])
      else $error("bad threshold stored or not flagged");
  a_cancel_back:
    assert property (cmd_cancel |=> st.edit == st.stored && $stable(st.stored))
      else $error("cancel did not restore the edit");
  a_apply_idle:
    assert property ($changed(st.active) |-> $past(st.pend)
      && !$past(sample_valid) && !$past(lim_valid))
      else $error("settings changed with a sample in flight");
endmodule
`default_nettype wire

// file: testbench/frl_detector_model.sv
// Flow detector stand-in: one flow sample per request from the bench
`timescale 1ns/1ps
`default_nettype none
module frl_detector_model (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        send,
  input  wire logic [15:0] value,
  output logic             sample_valid,
  output logic [15:0]      sample_value
);
  // ==============================================================
  // Sample pulse; stale data scrambled between samples
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sample_valid <= 1'b0;
      sample_value <= 16'h0000;
    end
    else
    begin
      sample_valid <= send;
      sample_value <= send ? value : ~sample_value;
    end
  end
endmodule
`default_nettype wire

// file: testbench/frl_flow_limit_tb.sv
// Self-checking bench for the flow filter top
`timescale 1ns/1ps
`default_nettype none
`include "frl_map.svh"
module frl_flow_limit_tb;
  typedef struct packed {
    logic [15:0] smp;
    logic [15:0] cur;
  } frl_row_t;
  logic        clk_sys, rstn, send, pulse_req, sample_valid, out_valid, pulse_out, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, brsp, rrsp;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] value, sample_value, current_value, display_value, comm_value;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  int          n_fail, tests_run, cycles;
  // Cutoff at 5.0 %, leave above 6.25 %
  frl_row_t    rows [8] = '{'{16'h00C8, 16'h00C8}, '{16'h0032, 16'h0000},
    '{16'h003C, 16'h0000}, '{16'h003E, 16'h0000}, '{16'h003F, 16'h003F},
    '{16'h0033, 16'h0033}, '{16'hFFD8, 16'h0000}, '{16'hFFBA, 16'hFFBA}};

  // ==============================================================
  // Design, detector and clock
  frl_flow_limit i_frl_flow_limit (.clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_valid(sample_valid),
    .sample_value(sample_value), .pulse_req(pulse_req), .out_valid(out_valid),
    .current_value(current_value), .display_value(display_value), .comm_value(comm_value),
    .pulse_out(pulse_out), .irq(irq));
  frl_detector_model i_frl_detector_model (.clk_sys(clk_sys), .rstn(rstn), .send(send),
    .value(value), .sample_valid(sample_valid), .sample_value(sample_value));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==============================================================
  // Helpers
  task automatic results();
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw = 1'b1;
    w  = 1'b1;
    while (aw || w)
    begin
      @(posedge clk_sys);
      if (aw && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      aw = aw && !s_axi_awready;
      w  = w && !s_axi_wready;
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Edit all settings, confirm, let them reach the filter
  task automatic cfg(input logic [8:0] r, input logic [4:0] h, input logic [6:0] c,
                     input logic d);
    wr(`FRL_A_RATE, 32'(r));
    wr(`FRL_A_HOLD, 32'(h));
    wr(`FRL_A_CUT, 32'(c));
    wr(`FRL_A_DSEL, 32'(d));
    wr(`FRL_A_CMD, 32'h0000_0001);
    repeat (4) @(posedge clk_sys);
  endtask
  // One sample through the detector, wait for the result
  task automatic smp(input logic [15:0] v);
    int n;
    @(posedge clk_sys);
    send  <= 1'b1;
    value <= v;
    @(posedge clk_sys);
    send <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (out_valid !== 1'b1 && n < 8);
    chk(16'(n), 16'h0002);
  endtask
  // One totalizer request, check whether it passes
  task automatic pls(input logic e);
    @(posedge clk_sys);
    pulse_req <= 1'b1;
    @(posedge clk_sys);
    pulse_req <= 1'b0;
    #1;
    chk(16'(pulse_out), 16'(e));
  endtask

  // ==============================================================
  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      results();
    end
  end

  // ==============================================================
  // Main sequence
  initial
  begin
    {rstn, send, pulse_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    value = 16'h0000;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk(current_value, 16'h0000);
    rd(`FRL_A_STATE);
    chk(rdat[15:0], 16'h0000);
    chk(16'(irq), 16'h0000);
    cfg(9'h000, 5'h00, 7'h32, 1'b1);
    rd(`FRL_A_STATUS);
    chk(16'(rdat[3]), 16'h0001);
    foreach (rows[i])
    begin
      smp(rows[i].smp);
      chk(current_value, rows[i].cur);
      chk(display_value, rows[i].cur);
      pls(rows[i].cur != 16'h0000);
    end
    // Out-of-range edits keep the stored values
    wr(`FRL_A_CUT, 32'h0000_0065);
    wr(`FRL_A_RATE, 32'h0000_012D);
    wr(`FRL_A_HOLD, 32'h0000_0015);
    wr(`FRL_A_CMD, 32'h0000_0001);
    rd(`FRL_A_CUT);
    chk(rdat[15:0], 16'h0032);
    rd(`FRL_A_RATE);
    chk(rdat[15:0], 16'h0000);
    rd(`FRL_A_HOLD);
    chk(rdat[15:0], 16'h0000);
    rd(`FRL_A_STATUS);
    chk(16'(rdat[0]), 16'h0001);
    // Cancelled edit never reaches the filter
    wr(`FRL_A_CUT, 32'h0000_0050);
    wr(`FRL_A_CMD, 32'h0000_0002);
    rd(`FRL_A_CUT);
    chk(rdat[15:0], 16'h0032);
    smp(16'h0046);
    chk(current_value, 16'h0046);
    // Display bypass under cutoff
    cfg(9'h000, 5'h00, 7'h32, 1'b0);
    smp(16'h001E);
    chk(current_value, 16'h0000);
    chk(display_value, 16'h001E);
    chk(comm_value, 16'h001E);
    pls(1'b0);
    // Limit 1.0 % per sample, hold 1 s of samples
    cfg(9'h00A, 5'h01, 7'h00, 1'b0);
    smp(16'h001E);
    for (int i = 0; i < 21; i++)
    begin
      smp(16'h01F4);
      chk(current_value, (i < 20) ? 16'(30 + 10 * (i + 1)) : 16'h01F4);
    end
    // Interrupt masked, raised, cleared
    wr(`FRL_A_ENABLE, 32'h0000_0000);
    chk(16'(irq), 16'h0000);
    wr(`FRL_A_ENABLE, 32'h0000_0004);
    repeat (2) @(posedge clk_sys);
    chk(16'(irq), 16'h0001);
    wr(`FRL_A_CLEAR, 32'h0000_0004);
    repeat (2) @(posedge clk_sys);
    chk(16'(irq), 16'h0000);
    rd(`FRL_A_STATUS);
    chk(16'(rdat[2]), 16'h0000);
    // Unmapped place
    rd(6'h24);
    chk(16'(rrsp), 16'(`FRL_SLVERR));
    chk(rdat[15:0], 16'h0000);
    wr(6'h24, 32'h0000_0001);
    chk(16'(brsp), 16'(`FRL_SLVERR));
    // Reset in mid-run drops outputs and settings
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk(current_value, 16'h0000);
    rd(`FRL_A_ENABLE);
    chk(rdat[15:0], 16'h0000);
    rd(`FRL_A_CUT);
    chk(rdat[15:0], 16'h0000);
    results();
  end
endmodule
`default_nettype wire
